// File: hdl/cfm_monitor.sv
// Fail-safe clock monitor with dual-speed start-up and an APB register slave
//
// How it works
// - Failure monitoring runs only while the monitor-enable config bit is set.
// - Low-frequency oscillator runs continuously whenever monitoring is enabled.
// - Sample clock is the low-frequency oscillator divided by 64.
// - Latch sets on monitored clock fall, clears on sample clock rise.
// - Latch still set at sample clock fall means clock failure.
// - Failure sets the oscillator-fail flag, bit 7 of interrupt flags 2.
// - Failure selects the internal block; oscillator control register keeps its select and frequency fields, running bit clears.
// - Every fail-safe event clears watchdog counter and postscaler.
// - Only primary or secondary sources are watched, never the internal block.
// - Disabling the watchdog never stops the oscillator while monitoring.
// - Fail-safe ends only on reset or power-managed mode entry.
// - After reset run internal, time primary start-up, switch, set running bit.
// - Primary never ready: stay internal, control register keeps reset value.
// - Power-managed entry selects the register's source and monitors it.
// - Failure in power-managed mode stays internal, no automatic switch back.
// - With fail interrupt off, later idle wake-ups run from internal source.
// - Clock input, RC or internal modes monitor immediately after wake; after reset they time start-up like crystal modes.
// - Crystal modes run internal until start-up and PLL timers expire, except after a wake with dual-speed and monitor enable both clear.
// - A primary that never starts raises no fail flag.
// - Start-up timer 1024 periods, PLL 2 ms, switch within 2-4 periods.
// - Running bit set while primary clocks the device, except during start-up after a wake without dual-speed; clear on internal.
// - Clock-select and Sleep accepted during start-up; primary stops unless the new mode selects it.
// - Dual-speed start-up always after reset; after wake when its configuration bit or monitor enable is set.
`include "cfm_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module cfm_monitor
    import cfm_pkg::*;
#(
    parameter int PLL_CYC = `CFM_PLL_LOCK_NS / `CFM_CLK_PERIOD_NS
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire cfm_apb_req_t apb_req,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         lfosc_clk,
    input  wire logic         dev_clk,
    input  wire logic         wake_evt,
    output cfm_mux_t          clk_mux_sel,
    output logic              primary_osc_en,
    output logic              lfosc_en,
    output logic              wdt_clear,
    output logic              osc_fail_irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cfm_fsm_t    st;
        logic [5:0]  cfg;
        logic [2:0]  freq_sel;
        logic [1:0]  clk_sel;
        logic        run_status;
        logic        fail_flag;
        logic        fail_ie;
        logic        latch;
        logic [15:0] cnt;
        logic        dev_prev;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        cfm_mux_t    mux;
        logic        pri_en;
        logic        lf_en;
        logic        wdt_clr;
        logic        irq;
    } cfm_mon_t;

    cfm_mon_t state_ff;
    cfm_mon_t nxt_state;

    logic [1:0] sync_q;
    logic       lf_s;
    logic       dev_s;
    logic       samp_rise;
    logic       samp_fall;
    logic       lf_run;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == CFM_XLOW) || (mode == CFM_XSTD) ||
                     (mode == CFM_XFAST) || (mode == CFM_XPLL);
    endfunction : is_crystal

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == `CFM_OFF_CFG)   || (addr == `CFM_OFF_OSCCTL) ||
                    (addr == `CFM_OFF_IRQF2) || (addr == `CFM_OFF_IRQE2)  ||
                    (addr == `CFM_OFF_PMCTL) || (addr == `CFM_OFF_STATUS);
    endfunction : is_mapped

    // ----------------------------------------------------------------
    // Input capture and sample clock
    // ----------------------------------------------------------------
    cfm_sync #(
        .W (2)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     ({lfosc_clk, dev_clk}),
        .dout    (sync_q)
    );

    assign lf_s  = sync_q[1];
    assign dev_s = sync_q[0];
    assign lf_run = state_ff.lf_en;

    cfm_sample_div #(
        .DIV (`CFM_SAMPLE_DIV)
    ) u_div (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .enable    (lf_run),
        .lf_level  (lf_s),
        .samp_rise (samp_rise),
        .samp_fall (samp_fall)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic        dev_fall;
        logic        mon_en;
        logic        crystal;
        logic        watching;
        logic        failed;
        logic        wr;
        logic        setup;
        logic        pm_enter;
        logic        sleep_cmd;
        logic        new_mode;
        logic        fail_clr;
        logic [31:0] rd;
        dev_fall  = 1'b0;
        mon_en    = 1'b0;
        crystal   = 1'b0;
        watching  = 1'b0;
        failed    = 1'b0;
        wr        = 1'b0;
        setup     = 1'b0;
        pm_enter  = 1'b0;
        sleep_cmd = 1'b0;
        new_mode  = 1'b0;
        fail_clr  = 1'b0;
        rd        = '0;
        nxt_state = state_ff;

        dev_fall = state_ff.dev_prev && !dev_s;
        nxt_state.dev_prev = dev_s;
        mon_en   = state_ff.cfg[`CFM_CFG_MON_BIT];
        crystal  = is_crystal(state_ff.cfg[`CFM_CFG_MODE_HI:`CFM_CFG_MODE_LO]);
        nxt_state.wdt_clr = 1'b0;

        // ------------------------------------------------------------
        // APB slave: zero-wait, pready one cycle after setup, in the first access-phase cycle
        // ------------------------------------------------------------
        setup = apb_req.psel && !apb_req.penable;
        wr    = apb_req.psel && apb_req.penable && state_ff.ready && apb_req.pwrite;
        nxt_state.ready  = setup;
        nxt_state.slverr = setup && !is_mapped(apb_req.paddr);
        case (apb_req.paddr)
            `CFM_OFF_CFG:    rd[5:0] = state_ff.cfg;
            `CFM_OFF_OSCCTL: begin
                rd[`CFM_OSC_FREQ_HI:`CFM_OSC_FREQ_LO] = state_ff.freq_sel;
                rd[`CFM_OSC_RUN_BIT]                  = state_ff.run_status;
                rd[`CFM_OSC_SEL_HI:`CFM_OSC_SEL_LO]   = state_ff.clk_sel;
            end
            `CFM_OFF_IRQF2:  rd[`CFM_IRQ_FAIL_BIT] = state_ff.fail_flag;
            `CFM_OFF_IRQE2:  rd[`CFM_IRQ_FAIL_BIT] = state_ff.fail_ie;
            `CFM_OFF_STATUS: rd = {26'h0, state_ff.latch, state_ff.lf_en,
                                   state_ff.pri_en, state_ff.st == CFM_ST_FAILSAFE,
                                   state_ff.mux};
            default:         rd = '0;
        endcase
        if (setup) begin
            nxt_state.rdata = rd;
        end

        if (wr) begin
            case (apb_req.paddr)
                `CFM_OFF_CFG: nxt_state.cfg = apb_req.pwdata[5:0];
                `CFM_OFF_OSCCTL: begin
                    // Oscillator control takes the written value; a frequency change clears the watchdog
                    nxt_state.freq_sel = apb_req.pwdata[`CFM_OSC_FREQ_HI:`CFM_OSC_FREQ_LO];
                    nxt_state.clk_sel  = apb_req.pwdata[`CFM_OSC_SEL_HI:`CFM_OSC_SEL_LO];
                    if (apb_req.pwdata[`CFM_OSC_FREQ_HI:`CFM_OSC_FREQ_LO]
                            != state_ff.freq_sel) begin
                        nxt_state.wdt_clr = 1'b1;
                    end
                end
                `CFM_OFF_IRQF2: fail_clr = !apb_req.pwdata[`CFM_IRQ_FAIL_BIT];
                `CFM_OFF_IRQE2: nxt_state.fail_ie = apb_req.pwdata[`CFM_IRQ_FAIL_BIT];
                `CFM_OFF_PMCTL: begin
                    pm_enter  = apb_req.pwdata[`CFM_PM_ENTER_BIT];
                    sleep_cmd = apb_req.pwdata[`CFM_PM_SLEEP_BIT];
                end
                default: ;
            endcase
        end
        new_mode = pm_enter || sleep_cmd;

        // ------------------------------------------------------------
        // Monitor latch and failure decision
        // ------------------------------------------------------------
        watching = mon_en && (state_ff.st == CFM_ST_MONITOR ||
                   (state_ff.st == CFM_ST_PM && state_ff.mux != CFM_MUX_INTERNAL));
        if (!watching) begin
            nxt_state.latch = 1'b0;
        end else if (dev_fall) begin
            nxt_state.latch = 1'b1;
        end else if (samp_rise) begin
            nxt_state.latch = 1'b0;
        end
        // Sample rise and fall are 32 edges apart, so one decision per period
        failed = watching && samp_fall && state_ff.latch;

        // Set wins over a software clear in the same cycle
        if (failed) begin
            nxt_state.fail_flag = 1'b1;
        end else if (fail_clr) begin
            nxt_state.fail_flag = 1'b0;
        end

        // ------------------------------------------------------------
        // Clock source sequencing
        // ------------------------------------------------------------
        case (state_ff.st)
            CFM_ST_WARM: begin
                // Primary may never start; no flag is raised while waiting
                if (dev_fall) begin
                    nxt_state.cnt = state_ff.cnt + 16'h1;
                end
                if (dev_fall && state_ff.cnt == 16'(`CFM_WARM_PERIODS - 1)) begin
                    nxt_state.cnt = '0;
                    nxt_state.st  = (state_ff.cfg[`CFM_CFG_MODE_HI:`CFM_CFG_MODE_LO]
                                     == CFM_XPLL) ? CFM_ST_PLL : CFM_ST_SWITCH;
                end
            end
            CFM_ST_PLL: begin
                nxt_state.cnt = state_ff.cnt + 16'h1;
                if (state_ff.cnt == 16'(PLL_CYC - 1)) begin
                    nxt_state.cnt = '0;
                    nxt_state.st  = CFM_ST_SWITCH;
                end
            end
            CFM_ST_SWITCH: begin
                if (dev_fall) begin
                    nxt_state.cnt = state_ff.cnt + 16'h1;
                end
                if (dev_fall && state_ff.cnt == 16'(`CFM_SWITCH_PERIODS - 1)) begin
                    nxt_state.cnt        = '0;
                    nxt_state.st         = CFM_ST_MONITOR;
                    nxt_state.mux        = CFM_MUX_PRIMARY;
                    nxt_state.run_status = 1'b1;
                end
            end
            CFM_ST_MONITOR, CFM_ST_PM: begin
                if (failed) begin
                    // Control register select and frequency fields not updated, only the running bit clears: this is the fail-safe condition
                    nxt_state.st         = CFM_ST_FAILSAFE;
                    nxt_state.mux        = CFM_MUX_INTERNAL;
                    nxt_state.run_status = 1'b0;
                    nxt_state.wdt_clr    = 1'b1;
                end
            end
            CFM_ST_FAILSAFE: begin
                // Stays on internal even for wake events with the interrupt off
                nxt_state.mux = CFM_MUX_INTERNAL;
            end
            CFM_ST_SLEEP: begin
                if (wake_evt) begin
                    nxt_state.cnt    = '0;
                    nxt_state.pri_en = 1'b1;
                    if (!crystal) begin
                        nxt_state.st         = CFM_ST_MONITOR;
                        nxt_state.mux        = CFM_MUX_PRIMARY;
                        nxt_state.run_status = 1'b1;
                    end else begin
                        nxt_state.st  = CFM_ST_WARM;
                        nxt_state.mux = state_ff.cfg[`CFM_CFG_DUAL_BIT] || mon_en ?
                                        CFM_MUX_INTERNAL : CFM_MUX_PRIMARY;
                    end
                end
            end
            default: nxt_state.st = CFM_ST_FAILSAFE;
        endcase

        // Mode change leaves fail-safe and cancels any pending start-up
        if (sleep_cmd) begin
            nxt_state.st         = CFM_ST_SLEEP;
            nxt_state.pri_en     = 1'b0;
            nxt_state.run_status = 1'b0;
            nxt_state.cnt        = '0;
            nxt_state.wdt_clr    = 1'b1;
        end else if (pm_enter) begin
            nxt_state.st  = CFM_ST_PM;
            nxt_state.cnt = '0;
            case (state_ff.clk_sel)
                2'h0: nxt_state.mux = CFM_MUX_PRIMARY;
                2'h1: nxt_state.mux = CFM_MUX_SECONDARY;
                default: nxt_state.mux = CFM_MUX_INTERNAL;
            endcase
            nxt_state.pri_en     = (state_ff.clk_sel == 2'h0);
            nxt_state.run_status = (state_ff.clk_sel == 2'h0);
        end
        if (new_mode && state_ff.st == CFM_ST_FAILSAFE) begin
            nxt_state.wdt_clr = 1'b1;
        end

        // Oscillator kept alive by monitor, watchdog or internal clock selection; monitor enable alone keeps it on
        nxt_state.lf_en = mon_en || state_ff.cfg[`CFM_CFG_WDT_BIT] ||
                          nxt_state.mux == CFM_MUX_INTERNAL;
        nxt_state.irq   = nxt_state.fail_flag && nxt_state.fail_ie;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff            <= '0;
            state_ff.st         <= CFM_ST_WARM;
            state_ff.cfg        <= `CFM_CFG_RST;
            state_ff.freq_sel   <= `CFM_FREQ_RST;
            state_ff.clk_sel    <= `CFM_SEL_RST;
            state_ff.mux        <= CFM_MUX_INTERNAL;
            state_ff.pri_en     <= 1'b1;
            state_ff.lf_en      <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata         = state_ff.rdata;
    assign pready         = state_ff.ready;
    assign pslverr        = state_ff.slverr;
    assign clk_mux_sel    = state_ff.mux;
    assign primary_osc_en = state_ff.pri_en;
    assign lfosc_en       = state_ff.lf_en;
    assign wdt_clear      = state_ff.wdt_clr;
    assign osc_fail_irq   = state_ff.irq;

endmodule : cfm_monitor

`default_nettype wire

// File: hdl/cfm_defines.svh
// Constants of the clock monitor
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CFM_OFF_CFG      8'h00
`define CFM_OFF_OSCCTL   8'h04
`define CFM_OFF_IRQF2    8'h08
`define CFM_OFF_IRQE2    8'h0C
`define CFM_OFF_PMCTL    8'h10
`define CFM_OFF_STATUS   8'h14
`define CFM_CFG_MON_BIT     0
`define CFM_CFG_DUAL_BIT    1
`define CFM_CFG_MODE_LO     2
`define CFM_CFG_MODE_HI     4
`define CFM_CFG_WDT_BIT     5
`define CFM_OSC_SEL_LO      0
`define CFM_OSC_SEL_HI      1
`define CFM_OSC_RUN_BIT     3
`define CFM_OSC_FREQ_LO     4
`define CFM_OSC_FREQ_HI     6
`define CFM_IRQ_FAIL_BIT    7
`define CFM_PM_ENTER_BIT    0
`define CFM_PM_SLEEP_BIT    1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CFM_CFG_RST      6'h0B
`define CFM_FREQ_RST     3'h0
`define CFM_SEL_RST      2'h0
`define CFM_CLK_PERIOD_NS   50
`define CFM_PLL_LOCK_NS     2000000
`define CFM_WARM_PERIODS    1024
`define CFM_SWITCH_PERIODS  2
`define CFM_SAMPLE_DIV      64

`endif

// File: hdl/cfm_pkg.sv
// Types shared by the clock monitor modules
package cfm_pkg;

    typedef enum logic [2:0] {
        CFM_XLOW, CFM_XSTD, CFM_XFAST, CFM_XPLL, CFM_EXTCLK, CFM_RCOSC, CFM_INTLF
    } cfm_osc_mode_t;

    typedef enum logic [1:0] {
        CFM_MUX_PRIMARY, CFM_MUX_SECONDARY, CFM_MUX_INTERNAL
    } cfm_mux_t;

    typedef enum {
        CFM_ST_WARM, CFM_ST_PLL, CFM_ST_SWITCH, CFM_ST_MONITOR,
        CFM_ST_FAILSAFE, CFM_ST_PM, CFM_ST_SLEEP
    } cfm_fsm_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cfm_apb_req_t;

endpackage : cfm_pkg

// File: hdl/cfm_sync.sv
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
`default_nettype none

module cfm_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cfm_sync_t;

    cfm_sync_t state_ff;
    cfm_sync_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        for (int i = 0; i < W; i++) begin
            nxt_state.meta[i]   = din[i];
            nxt_state.stable[i] = state_ff.meta[i];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dout = state_ff.stable;

endmodule : cfm_sync

`default_nettype wire

// File: hdl/cfm_sample_div.sv
// Divides the low-frequency oscillator into the monitor sample clock
`include "cfm_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module cfm_sample_div #(
    parameter int DIV = `CFM_SAMPLE_DIV
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic lf_level,
    output logic      samp_rise,
    output logic      samp_fall
);
    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic          prev;
        logic [CW-1:0] cnt;
        logic          rise;
        logic          fall;
    } cfm_div_t;

    cfm_div_t state_ff;
    cfm_div_t nxt_state;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.prev = lf_level;
        nxt_state.rise = 1'b0;
        nxt_state.fall = 1'b0;
        if (!enable) begin
            nxt_state.cnt = '0;
        end else if (lf_level && !state_ff.prev) begin
            // Sample clock is the counter MSB: high for half of DIV periods
            nxt_state.cnt  = state_ff.cnt + 1'b1;
            nxt_state.rise = (state_ff.cnt == CW'(DIV / 2 - 1));
            nxt_state.fall = (state_ff.cnt == CW'(DIV - 1));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign samp_rise = state_ff.rise;
    assign samp_fall = state_ff.fall;

endmodule : cfm_sample_div

`default_nettype wire

// File: dv/cfm_monitor_asserts.sv
// Port-level assertions for the clock monitor
`timescale 1ns/1ns
`default_nettype none
`include "cfm_defines.svh"

module cfm_monitor_chk
    import cfm_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire cfm_apb_req_t apb_req,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire cfm_mux_t     clk_mux_sel,
    input wire logic         primary_osc_en,
    input wire logic         lfosc_en,
    input wire logic         wdt_clear,
    input wire logic         osc_fail_irq
);
    logic mon_en_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Monitor enable as last written
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mon_en_ff <= 1'b1;
        end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && pready
                     && apb_req.paddr == `CFM_OFF_CFG) begin
            mon_en_ff <= apb_req.pwdata[`CFM_CFG_MON_BIT];
        end
    end

    a_reset_outputs: assert property (
        $rose(rst_n) |-> clk_mux_sel == CFM_MUX_INTERNAL && primary_osc_en && lfosc_en && !wdt_clear)
        else $error("outputs wrong after reset");
    a_ready_next: assert property (
        apb_req.psel && !apb_req.penable |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready held too long");
    a_error_zero: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("refused read not zero");
    a_wdt_pulse: assert property (
        wdt_clear |=> !wdt_clear) else $error("clear not a pulse");
    a_fail_switch: assert property (
        $rose(osc_fail_irq) && $past(clk_mux_sel, 2) == CFM_MUX_PRIMARY
        |-> clk_mux_sel == CFM_MUX_INTERNAL && (wdt_clear || $past(wdt_clear)))
        else $error("no switch on failure");
    // Recent writes may be mode entries
    a_failsafe_holds: assert property (
        osc_fail_irq && clk_mux_sel == CFM_MUX_INTERNAL && !apb_req.psel
        && !$past(apb_req.psel) && !$past(apb_req.psel, 2) |=> clk_mux_sel == CFM_MUX_INTERNAL)
        else $error("fail-safe left early");
    a_lf_kept_on: assert property (
        mon_en_ff && $past(mon_en_ff, 2) |-> lfosc_en) else $error("oscillator off");
endmodule : cfm_monitor_chk

bind cfm_monitor cfm_monitor_chk chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_mux_sel(clk_mux_sel),
    .primary_osc_en(primary_osc_en), .lfosc_en(lfosc_en), .wdt_clear(wdt_clear),
    .osc_fail_irq(osc_fail_irq)
);
`default_nettype wire

// File: dv/cfm_xtal_model.sv
// Primary oscillator model
`timescale 1ns/1ns
`default_nettype none

module cfm_xtal_model (
    input  wire logic       clk_sys,
    input  wire logic       osc_en,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output var  logic       dev_clk
);
    logic [3:0] cnt_ff = 4'h0;

    initial dev_clk = 1'b0;
    // A disabled or dead crystal freezes at its last level
    always @(posedge clk_sys) begin
        if (osc_en && run) begin
            cnt_ff <= (cnt_ff + 4'h1 >= half) ? 4'h0 : cnt_ff + 4'h1;
            if (cnt_ff + 4'h1 >= half) begin
                dev_clk <= ~dev_clk;
            end
        end
    end
endmodule : cfm_xtal_model
`default_nettype wire

// File: dv/cfm_monitor_tb.sv
// Self-checking testbench for the clock monitor
`timescale 1ns/1ns
`default_nettype none
`include "cfm_defines.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end

module cfm_monitor_tb
    import cfm_pkg::*;
;
    logic         clk_sys, rst_n = 1'b0, wake_evt = 1'b0, lfosc_clk = 1'b0, dev_run = 1'b1;
    logic         pready, pslverr, primary_osc_en, lfosc_en, wdt_clear, osc_fail_irq, dev_clk;
    logic         rd_e;
    logic [31:0]  prdata, rd_q;
    logic [3:0]   dev_half = 4'h3;
    logic [2:0]   f;
    logic [1:0]   lf_cnt_ff = 2'h0;
    cfm_apb_req_t apb_req = '0;
    cfm_mux_t     clk_mux_sel;
    int           n_tests = 0, miscompares = 0, n_fall = 0, n_wdt = 0, w;

    cfm_monitor #(.PLL_CYC(20)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lfosc_clk(lfosc_clk),
        .dev_clk(dev_clk), .wake_evt(wake_evt), .clk_mux_sel(clk_mux_sel),
        .primary_osc_en(primary_osc_en), .lfosc_en(lfosc_en), .wdt_clear(wdt_clear),
        .osc_fail_irq(osc_fail_irq));
    cfm_xtal_model osc_u (.clk_sys(clk_sys), .osc_en(primary_osc_en), .run(dev_run),
        .half(dev_half), .dev_clk(dev_clk));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Slow oscillator, 8 cycles a period: 512 per sample period
    always @(posedge clk_sys) begin
        if (lfosc_en) begin
            lf_cnt_ff <= lf_cnt_ff + 2'h1;
            if (lf_cnt_ff == 2'h3) begin
                lfosc_clk <= ~lfosc_clk;
            end
        end
    end
    always @(negedge dev_clk) n_fall++;
    always @(posedge clk_sys) if (wdt_clear === 1'b1) n_wdt++;

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd_q = prdata;
        rd_e = pslverr;
        apb_req <= '0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK("read data", x, rd_q & m)
    endtask : rchk

    task automatic wait_mux(input cfm_mux_t v, input int lim);
        for (int n = 0; n < lim && clk_mux_sel !== v; n++) @(posedge clk_sys);
        `CHK("mux", v, clk_mux_sel)
    endtask : wait_mux

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(89));
        f = 3'($urandom_range(7));
        dev_half = 4'(3 + $urandom_range(2));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        n_fall = 0;
        @(posedge clk_sys);
        `CHK("mux", CFM_MUX_INTERNAL, clk_mux_sel)
        `CHK("lf enable", 1'b1, lfosc_en)
        rchk(`CFM_OFF_CFG, 32'h3F, 32'h0B);
        rchk(`CFM_OFF_OSCCTL, 32'h7F, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        `CHK("slverr", 1'b1, rd_e)
        apb(1'b1, `CFM_OFF_IRQE2, 32'h80);
        apb(1'b1, `CFM_OFF_OSCCTL, {25'h0, f, 4'h0});
        $display("test reset done");
        wait_mux(CFM_MUX_PRIMARY, 30000);
        `CHK("osc falls", 1'b1, n_fall >= 1025 && n_fall <= 1028)
        rchk(`CFM_OFF_OSCCTL, 32'h08, 32'h08);
        w = n_wdt;
        wait_mux(CFM_MUX_INTERNAL, 528);
        repeat (2) @(posedge clk_sys);
        `CHK("fail irq", 1'b1, osc_fail_irq)
        `CHK("wdt clears", w + 1, n_wdt)
        rchk(`CFM_OFF_IRQF2, 32'h80, 32'h80);
        rchk(`CFM_OFF_OSCCTL, 32'h73, {25'h0, f, 4'h0});
        repeat (600) @(posedge clk_sys);
        `CHK("mux", CFM_MUX_INTERNAL, clk_mux_sel)
        $display("test failure done");
        apb(1'b1, `CFM_OFF_PMCTL, 32'h1);
        wait_mux(CFM_MUX_PRIMARY, 20);
        wait_mux(CFM_MUX_INTERNAL, 528);
        repeat (600) @(posedge clk_sys);
        `CHK("mux", CFM_MUX_INTERNAL, clk_mux_sel)
        apb(1'b1, `CFM_OFF_IRQF2, 32'h0);
        rchk(`CFM_OFF_IRQF2, 32'h80, 32'h0);
        apb(1'b1, `CFM_OFF_OSCCTL, {25'h0, f, 4'h2});
        apb(1'b1, `CFM_OFF_PMCTL, 32'h1);
        repeat (1100) @(posedge clk_sys);
        `CHK("fail irq", 1'b0, osc_fail_irq)
        $display("test mode entry done");
        apb(1'b1, `CFM_OFF_CFG, 32'h10);
        apb(1'b1, `CFM_OFF_OSCCTL, {25'h0, f, 4'h0});
        apb(1'b1, `CFM_OFF_PMCTL, 32'h1);
        wait_mux(CFM_MUX_PRIMARY, 20);
        repeat (1100) @(posedge clk_sys);
        `CHK("fail irq", 1'b0, osc_fail_irq)
        apb(1'b1, `CFM_OFF_PMCTL, 32'h2);
        apb(1'b1, `CFM_OFF_CFG, 32'h11);
        wake_evt <= 1'b1;
        @(posedge clk_sys);
        wake_evt <= 1'b0;
        wait_mux(CFM_MUX_PRIMARY, 20);
        wait_mux(CFM_MUX_INTERNAL, 528);
        $display("test wake done");
        rst_n <= 1'b0;
        dev_run <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2000) @(posedge clk_sys);
        `CHK("mux", CFM_MUX_INTERNAL, clk_mux_sel)
        rchk(`CFM_OFF_IRQF2, 32'h80, 32'h0);
        rchk(`CFM_OFF_OSCCTL, 32'h7F, 32'h0);
        apb(1'b1, `CFM_OFF_OSCCTL, 32'h2);
        apb(1'b1, `CFM_OFF_PMCTL, 32'h1);
        repeat (4) @(posedge clk_sys);
        `CHK("primary enable", 1'b0, primary_osc_en)
        $display("test dead osc done");
        end_sim;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        end_sim;
    end
endmodule : cfm_monitor_tb
`default_nettype wire
